// file: hw/iaa_exec.sv
// Execute unit: register file, index pointers, moves, add/sub and logic.
// Assumes predecoded commands and a data memory that answers with ready.
//
// Contract
// - Four 16-bit index pointers, each a register pair, for indirect access.
// - Pointers give data byte addresses; long jump may take one as target.
// - Indexed access may hold, pre-increment, post-increment or post-decrement.
// - Reset clears all four index pointers to zero.
// - Immediate-relative address is fixed-base pointer plus unsigned immediate.
// - Register-relative address is chosen pointer plus unsigned accumulator.
// - Relative forms are decoded only for the byte move.
// - A move transfers exactly one byte between register, memory, immediate.
// - Immediate to memory uses an unmodified pointer only.
// - Immediate-relative moves use a limited register operand.
// - Arithmetic is 8-bit two's complement add and subtract only.
// - Add and subtract: with accumulator, with carry, and immediate.
// - Accumulator forms may write a separate register or memory destination.
// - The implied accumulator belongs to the selected register bank.
// - Immediate add/subtract use one register as source and destination.
// - Logic ops are 8-bit and, or, exclusive or, and invert.
// - And, or, xor take immediate or accumulator; only the accumulator forms' destination may differ.
// - Invert takes one register as both source and destination.
// - Limited operands reach the first 28 locations, 16 visible.
// - Full operands reach 32 of 44 registers; lowest twelve are banked.
// - Accumulator subtract takes accumulator from the source register.
`timescale 1ns/1ps
module iaa_exec (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire iaa_pkg::iaa_op_e cmd_op,
    input wire iaa_pkg::iaa_amode_e cmd_amode,
    input wire iaa_pkg::iaa_imode_e cmd_imode,
    input wire logic [1:0] cmd_ix,
    input wire logic [4:0] cmd_src,
    input wire logic [4:0] cmd_dst,
    input wire logic cmd_dst_mem,
    input wire logic [7:0] cmd_imm,
    input wire logic bank_sel,
    output logic [15:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    input wire logic [7:0] dmem_rdata,
    output logic dmem_we,
    output logic dmem_re,
    input wire logic dmem_ready,
    output logic jump_valid,
    output logic [15:0] jump_addr,
    output logic done,
    output logic flag_carry,
    output logic flag_zero,
    output logic flag_neg,
    output logic flag_ovf,
    input wire logic [5:0] peek_sel,
    output logic [7:0] peek_data
);
    import iaa_pkg::*;

    // Banked locations R0..R11 live twice, once per bank.
    function automatic logic [5:0] phys_map(input logic [4:0] r,
                                            input logic bank);
        return (r >= BANKED_LIMIT || bank) ? {1'b0, r} + BANK_STRIDE
                                           : {1'b0, r};
    endfunction

    function automatic logic [5:0] limited_map(input logic [4:0] r,
                                               input logic bank);
        return phys_map({1'b0, r[3:0]}, bank);
    endfunction

    function automatic logic [5:0] ix_low(input logic [1:0] ix,
                                          input logic bank);
        return phys_map(IX_BASE_REG + {2'b00, ix, 1'b0}, bank);
    endfunction

    logic [7:0] regs_q [NUM_PHYS], regs_d [NUM_PHYS];
    iaa_state_e state_q, state_d;
    logic [15:0] dmem_addr_q, dmem_addr_d;
    logic [7:0] dmem_wdata_q, dmem_wdata_d;
    logic dmem_we_q, dmem_we_d, dmem_re_q, dmem_re_d;
    logic [5:0] rd_p_q, rd_p_d;
    logic [1:0] upd_ix_q, upd_ix_d;
    logic [15:0] upd_ptr_q, upd_ptr_d;
    logic jump_valid_q, jump_valid_d, done_q, done_d;
    logic [15:0] jump_addr_q, jump_addr_d;
    logic [3:0] flags_q, flags_d;
    logic [7:0] peek_q;

    logic accept, is_move_mem, rel_ok;
    iaa_amode_e am;
    iaa_imode_e im;
    iaa_fn_e fn;
    logic [1:0] ix_sel;
    logic [5:0] ix_p, wr_p;
    logic [15:0] ix_val, ea, ptr_next;
    logic [7:0] acc_val, src_val, lim_src_val, lim_dst_val, full_dst_val;
    logic [7:0] offset, alu_a, alu_b, alu_res, wr_data;
    logic alu_cin, alu_cout, alu_ovf, use_alu, arith, wr_en, ptr_commit;

    assign cmd_ready = (state_q == ST_IDLE);
    assign accept = cmd_valid && cmd_ready;

    // Relative forms only ever apply to the byte move.
    assign is_move_mem = (cmd_op == OP_MOV_RM) || (cmd_op == OP_MOV_MR);
    assign rel_ok = is_move_mem && (cmd_amode != AM_INDEXED);
    assign am = rel_ok ? cmd_amode : AM_INDEXED;
    // Immediate stores and relative forms never touch the pointer.
    assign im = (rel_ok || cmd_op == OP_MOV_IM) ? IM_HOLD : cmd_imode;
    assign ix_sel = (am == AM_IMM_REL) ? FIXED_BASE_IX : cmd_ix;
    assign ix_p = ix_low(ix_sel, bank_sel);
    assign ix_val = {regs_q[ix_p + 6'h01], regs_q[ix_p]};
    // Accumulator follows the active bank.
    assign acc_val = regs_q[phys_map(ACC_REG, bank_sel)];
    assign src_val = regs_q[phys_map(cmd_src, bank_sel)];
    assign lim_src_val = regs_q[limited_map(cmd_src, bank_sel)];
    assign lim_dst_val = regs_q[limited_map(cmd_dst, bank_sel)];
    assign full_dst_val = regs_q[phys_map(cmd_dst, bank_sel)];
    assign offset = (am == AM_IMM_REL) ? cmd_imm : acc_val;

    iaa_addr_gen u_addr_gen (
        .ptr(ix_val),
        .amode(am),
        .imode(im),
        .offset(offset),
        .addr(ea),
        .ptr_next(ptr_next)
    );

    iaa_alu u_alu (
        .fn(fn),
        .a(alu_a),
        .b(alu_b),
        .cin(alu_cin),
        .res(alu_res),
        .cout(alu_cout),
        .ovf(alu_ovf)
    );

    // Operand selection for the ALU forms.
    always_comb begin
        fn = FN_ADD;
        alu_a = src_val;
        alu_b = acc_val;
        alu_cin = 1'b0;
        use_alu = 1'b1;
        arith = 1'b0;
        if (cmd_op inside {OP_ADD_I, OP_SUB_I, OP_AND_I, OP_OR_I,
                           OP_XOR_I}) begin
            alu_a = lim_dst_val;
            alu_b = cmd_imm;
        end
        case (cmd_op)
            OP_ADD_I, OP_ADD_A: arith = 1'b1;
            OP_ADC_A: begin
                alu_cin = flags_q[0];
                arith = 1'b1;
            end
            OP_SUB_I, OP_SUB_A: begin
                fn = FN_SUB;
                arith = 1'b1;
            end
            OP_SBC_A: begin
                fn = FN_SUB;
                alu_cin = flags_q[0];
                arith = 1'b1;
            end
            OP_AND_I, OP_AND_A: fn = FN_AND;
            OP_OR_I, OP_OR_A: fn = FN_OR;
            OP_XOR_I, OP_XOR_A: fn = FN_XOR;
            OP_INV: begin
                fn = FN_INV;
                alu_a = full_dst_val;
            end
            default: use_alu = 1'b0;
        endcase
    end

    // Command sequencing and register writeback.
    always_comb begin
        state_d = state_q;
        dmem_addr_d = dmem_addr_q;
        dmem_wdata_d = dmem_wdata_q;
        dmem_we_d = dmem_we_q;
        dmem_re_d = dmem_re_q;
        rd_p_d = rd_p_q;
        upd_ix_d = upd_ix_q;
        upd_ptr_d = upd_ptr_q;
        jump_valid_d = 1'b0;
        jump_addr_d = jump_addr_q;
        done_d = 1'b0;
        flags_d = flags_q;
        wr_en = 1'b0;
        wr_p = phys_map(cmd_dst, bank_sel);
        wr_data = alu_res;
        ptr_commit = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    upd_ix_d = ix_sel;
                    upd_ptr_d = ptr_next;
                    dmem_addr_d = ea;
                    if (use_alu) begin
                        flags_d[1] = (alu_res == 8'h00);
                        flags_d[2] = alu_res[7];
                        flags_d[3] = arith ? alu_ovf : 1'b0;
                        if (arith) begin
                            flags_d[0] = alu_cout;
                        end
                    end
                    case (cmd_op)
                        OP_MOV_RR: begin
                            wr_en = 1'b1;
                            wr_data = src_val;
                            done_d = 1'b1;
                        end
                        OP_MOV_IR: begin
                            wr_en = 1'b1;
                            wr_p = limited_map(cmd_dst, bank_sel);
                            wr_data = cmd_imm;
                            done_d = 1'b1;
                        end
                        OP_MOV_RM: begin
                            // Limited source for immediate-relative.
                            dmem_wdata_d = (am == AM_IMM_REL) ? lim_src_val
                                                              : src_val;
                            dmem_we_d = 1'b1;
                            state_d = ST_MEM_WR;
                        end
                        OP_MOV_IM: begin
                            dmem_wdata_d = cmd_imm;
                            dmem_we_d = 1'b1;
                            state_d = ST_MEM_WR;
                        end
                        OP_MOV_MR: begin
                            rd_p_d = (am == AM_IMM_REL)
                                     ? limited_map(cmd_dst, bank_sel)
                                     : phys_map(cmd_dst, bank_sel);
                            dmem_re_d = 1'b1;
                            state_d = ST_MEM_RD;
                        end
                        OP_ADD_I, OP_SUB_I, OP_AND_I, OP_OR_I,
                        OP_XOR_I: begin
                            wr_en = 1'b1;
                            wr_p = limited_map(cmd_dst, bank_sel);
                            done_d = 1'b1;
                        end
                        OP_INV: begin
                            wr_en = 1'b1;
                            done_d = 1'b1;
                        end
                        OP_ABSOLUTE_LONG_JUMP_IX: begin
                            // Pointer read as an instruction word address.
                            jump_addr_d = ix_val;
                            jump_valid_d = 1'b1;
                            done_d = 1'b1;
                        end
                        default: begin
                            // Accumulator forms write memory or a register.
                            if (cmd_dst_mem) begin
                                dmem_wdata_d = alu_res;
                                dmem_we_d = 1'b1;
                                state_d = ST_MEM_WR;
                            end else begin
                                wr_en = 1'b1;
                                done_d = 1'b1;
                            end
                        end
                    endcase
                end
            end
            ST_MEM_RD, ST_MEM_WR: begin
                if (dmem_ready) begin
                    wr_en = dmem_re_q;
                    wr_p = rd_p_q;
                    wr_data = dmem_rdata;
                    ptr_commit = 1'b1;
                    dmem_we_d = 1'b0;
                    dmem_re_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                dmem_we_d = 1'b0;
                dmem_re_d = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    // The loaded byte is written after the pointer so that it wins when
    // the destination is half of the pointer being stepped.
    always_comb begin
        logic [5:0] up;
        up = ix_low(upd_ix_q, bank_sel);
        regs_d = regs_q;
        if (ptr_commit) begin
            regs_d[up] = upd_ptr_q[7:0];
            regs_d[up + 6'h01] = upd_ptr_q[15:8];
        end
        if (wr_en) begin
            regs_d[wr_p] = wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            // Whole file cleared, index pairs among it.
            for (int i = 0; i < NUM_PHYS; i++) begin
                regs_q[i] <= REG_RESET;
            end
            state_q <= ST_IDLE;
            dmem_addr_q <= 16'h0000;
            dmem_wdata_q <= 8'h00;
            dmem_we_q <= 1'b0;
            dmem_re_q <= 1'b0;
            rd_p_q <= 6'h00;
            upd_ix_q <= 2'h0;
            upd_ptr_q <= 16'h0000;
            jump_valid_q <= 1'b0;
            jump_addr_q <= 16'h0000;
            done_q <= 1'b0;
            flags_q <= 4'h0;
            peek_q <= 8'h00;
        end else begin
            regs_q <= regs_d;
            state_q <= state_d;
            dmem_addr_q <= dmem_addr_d;
            dmem_wdata_q <= dmem_wdata_d;
            dmem_we_q <= dmem_we_d;
            dmem_re_q <= dmem_re_d;
            rd_p_q <= rd_p_d;
            upd_ix_q <= upd_ix_d;
            upd_ptr_q <= upd_ptr_d;
            jump_valid_q <= jump_valid_d;
            jump_addr_q <= jump_addr_d;
            done_q <= done_d;
            flags_q <= flags_d;
            peek_q <= (int'(peek_sel) < NUM_PHYS) ? regs_q[peek_sel] : 8'h00;
        end
    end

    assign dmem_addr = dmem_addr_q;
    assign dmem_wdata = dmem_wdata_q;
    assign dmem_we = dmem_we_q;
    assign dmem_re = dmem_re_q;
    assign jump_valid = jump_valid_q;
    assign jump_addr = jump_addr_q;
    assign done = done_q;
    assign {flag_ovf, flag_neg, flag_zero, flag_carry} = flags_q;
    assign peek_data = peek_q;
endmodule

// file: shared/iaa_pkg.sv
// Shared constants and types of the index addressing and ALU execute unit.
// Assumes one 20 MHz core clock and a fetch stage that predecodes commands.
package iaa_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int REG_SEL_W = 5;
    localparam int LIM_SEL_W = 4;
    localparam int PHYS_W = 6;
    localparam int NUM_PHYS = 44;
    localparam int NUM_IX = 4;
    localparam int CLK_PERIOD_NS = 50;

    // Visible registers below this number are banked.
    localparam logic [4:0] BANKED_LIMIT = 5'h0C;
    localparam logic [5:0] BANK_STRIDE = 6'h0C;
    // Index pointer k is the visible pair R(24+2k) low, R(25+2k) high.
    localparam logic [4:0] IX_BASE_REG = 5'h18;
    // The accumulator is R0 of the active bank.
    localparam logic [4:0] ACC_REG = 5'h00;
    localparam logic [1:0] FIXED_BASE_IX = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    typedef enum logic [4:0] {
        OP_MOV_RR = 5'h00,
        OP_MOV_RM = 5'h01,
        OP_MOV_MR = 5'h02,
        OP_MOV_IR = 5'h03,
        OP_MOV_IM = 5'h04,
        OP_ADD_I = 5'h05,
        OP_SUB_I = 5'h06,
        OP_ADD_A = 5'h07,
        OP_ADC_A = 5'h08,
        OP_SUB_A = 5'h09,
        OP_SBC_A = 5'h0A,
        OP_AND_I = 5'h0B,
        OP_OR_I = 5'h0C,
        OP_XOR_I = 5'h0D,
        OP_AND_A = 5'h0E,
        OP_OR_A = 5'h0F,
        OP_XOR_A = 5'h10,
        OP_INV = 5'h11,
        OP_ABSOLUTE_LONG_JUMP_IX = 5'h12
    } iaa_op_e;

    typedef enum logic [1:0] {
        AM_INDEXED = 2'h0,
        AM_IMM_REL = 2'h1,
        AM_REG_REL = 2'h2
    } iaa_amode_e;

    typedef enum logic [1:0] {
        IM_HOLD = 2'h0,
        IM_POST_DEC = 2'h1,
        IM_POST_INC = 2'h2,
        IM_PRE_INC = 2'h3
    } iaa_imode_e;

    typedef enum logic [2:0] {
        FN_ADD = 3'h0,
        FN_SUB = 3'h1,
        FN_AND = 3'h2,
        FN_OR = 3'h3,
        FN_XOR = 3'h4,
        FN_INV = 3'h5
    } iaa_fn_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MEM_RD = 3'h2,
        ST_MEM_WR = 3'h4
    } iaa_state_e;
endpackage

// file: hw/iaa_addr_gen.sv
// Data address former for indexed and relative operands.
// Assumes the caller commits the returned pointer value itself.
`timescale 1ns/1ps
module iaa_addr_gen (
    input wire logic [15:0] ptr,
    input wire iaa_pkg::iaa_amode_e amode,
    input wire iaa_pkg::iaa_imode_e imode,
    input wire logic [7:0] offset,
    output logic [15:0] addr,
    output logic [15:0] ptr_next
);
    import iaa_pkg::*;

    always_comb begin
        addr = ptr;
        ptr_next = ptr;
        if (amode != AM_INDEXED) begin
            // Sixteen-bit sum wraps on its own.
            addr = ptr + {8'h00, offset};
        end else begin
            case (imode)
                IM_PRE_INC: begin
                    ptr_next = ptr + PTR_STEP;
                    addr = ptr_next;
                end
                IM_POST_INC: begin
                    ptr_next = ptr + PTR_STEP;
                end
                IM_POST_DEC: begin
                    ptr_next = ptr - PTR_STEP;
                end
                default: begin
                    ptr_next = ptr;
                end
            endcase
        end
    end
endmodule

// file: hw/iaa_alu.sv
// Eight-bit add, subtract and logic unit.
// Assumes carry in means borrow for subtraction.
`timescale 1ns/1ps
module iaa_alu (
    input wire iaa_pkg::iaa_fn_e fn,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] res,
    output logic cout,
    output logic ovf
);
    import iaa_pkg::*;

    logic [8:0] wide;

    always_comb begin
        wide = 9'h000;
        res = 8'h00;
        cout = 1'b0;
        ovf = 1'b0;
        case (fn)
            FN_ADD: begin
                // Signed overflow when like signs give an unlike sum.
                wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                res = wide[7:0];
                cout = wide[8];
                ovf = (a[7] == b[7]) && (res[7] != a[7]);
            end
            FN_SUB: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                res = wide[7:0];
                cout = wide[8];
                ovf = (a[7] != b[7]) && (res[7] != a[7]);
            end
            FN_AND: res = a & b;
            FN_OR: res = a | b;
            FN_XOR: res = a ^ b;
            FN_INV: res = ~a;
            default: res = a;
        endcase
    end
endmodule

// file: testbench/iaa_exec_monitor.sv
// Port-level checks for the execute unit.
// Assumes it is bound to iaa_exec and shares its single clock.
`timescale 1ns/1ps
module iaa_exec_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire iaa_pkg::iaa_op_e cmd_op,
    input wire logic [7:0] cmd_imm,
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    input wire logic dmem_re,
    input wire logic dmem_ready,
    input wire logic jump_valid,
    input wire logic done
);
    import iaa_pkg::*;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    wire acc = cmd_valid && cmd_ready;
    wire busy = dmem_we || dmem_re;

    chk_reset_quiet: assert property (
        $fell(rst) |-> !done && !busy && !jump_valid)
        else $error("outputs not idle after reset");
    chk_done_cause: assert property (
        done |-> $past(acc) || $past(busy && dmem_ready))
        else $error("done without a cause");
    chk_one_access: assert property (
        !(dmem_we && dmem_re))
        else $error("read and write together");
    chk_access_hold: assert property (
        busy && !dmem_ready |=> $stable(dmem_addr) && $stable(dmem_wdata)
            && $stable(dmem_we) && $stable(dmem_re))
        else $error("access changed while waiting");
    chk_access_end: assert property (
        busy && dmem_ready |=> !busy && done)
        else $error("access did not end");
    chk_busy_refuse: assert property (
        busy |-> !cmd_ready)
        else $error("ready during access");
    chk_imm_write: assert property (
        acc && cmd_op == OP_MOV_IM |=> dmem_we && dmem_wdata == $past(cmd_imm))
        else $error("immediate write wrong");
    chk_reg_only: assert property (
        acc && cmd_op inside {OP_ADD_I, OP_SUB_I, OP_INV} |=> done && !busy)
        else $error("register op touched memory");
    chk_jump_pulse: assert property (
        acc && cmd_op == OP_ABSOLUTE_LONG_JUMP_IX |=> jump_valid)
        else $error("jump not signalled");
endmodule

bind iaa_exec iaa_exec_monitor iaa_exec_monitor_inst (.core_clk, .rst,
    .cmd_valid, .cmd_ready, .cmd_op, .cmd_imm, .dmem_addr, .dmem_wdata,
    .dmem_we, .dmem_re, .dmem_ready, .jump_valid, .done);

// file: testbench/iaa_dmem_model.sv
// Byte-wide data memory with a programmable number of wait cycles.
// Assumes requests hold steady until ready, as the execute unit promises.
`timescale 1ns/1ps
module iaa_dmem_model (
    input wire logic core_clk,
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    input wire logic dmem_re,
    input wire logic [3:0] wait_cyc,
    output logic [7:0] dmem_rdata,
    output logic dmem_ready
);
    logic [7:0] store [0:65535];
    logic [3:0] cnt;
    initial begin
        dmem_rdata = 8'h00;
        dmem_ready = 1'b0;
        cnt = 4'h0;
    end
    // Read data toggles outside a transfer so a stale byte is never trusted.
    always @(posedge core_clk) begin
        dmem_ready <= 1'b0;
        dmem_rdata <= ~dmem_rdata;
        if ((dmem_we || dmem_re) && !dmem_ready) begin
            if (cnt >= wait_cyc) begin
                cnt <= 4'h0;
                dmem_ready <= 1'b1;
                if (dmem_we) begin
                    store[dmem_addr] <= dmem_wdata;
                end else begin
                    dmem_rdata <= store[dmem_addr];
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the execute unit and its data memory.
// Assumes the bound monitor and the memory model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import iaa_pkg::*;
    logic core_clk, rst, cmd_valid, cmd_ready, cmd_dst_mem, bank_sel;
    logic dmem_we, dmem_re, dmem_ready, jump_valid, done, dm, bk;
    logic flag_carry, flag_zero, flag_neg, flag_ovf;
    iaa_op_e cmd_op;
    iaa_amode_e cmd_amode, am;
    iaa_imode_e cmd_imode, im;
    logic [1:0] cmd_ix;
    logic [4:0] cmd_src, cmd_dst;
    logic [7:0] cmd_imm, dmem_wdata, dmem_rdata, peek_data, rv;
    logic [15:0] dmem_addr, jump_addr;
    logic [5:0] peek_sel;
    logic [3:0] wait_cyc;
    int fail_count, total_checks;

    iaa_exec iaa_exec_inst (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_amode, .cmd_imode, .cmd_ix, .cmd_src, .cmd_dst, .cmd_dst_mem,
        .cmd_imm, .bank_sel, .dmem_addr, .dmem_wdata, .dmem_rdata, .dmem_we,
        .dmem_re, .dmem_ready, .jump_valid, .jump_addr, .done, .flag_carry,
        .flag_zero, .flag_neg, .flag_ovf, .peek_sel, .peek_data);
    iaa_dmem_model iaa_dmem_model_inst (.core_clk, .dmem_addr, .dmem_wdata,
        .dmem_we, .dmem_re, .wait_cyc, .dmem_rdata, .dmem_ready);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task final_report;
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    function automatic logic [7:0] mem(input logic [15:0] a);
        return iaa_dmem_model_inst.store[a];
    endfunction

    function automatic logic [5:0] ph(input logic [4:0] r);
        return (r < 5'h0C && !bank_sel) ? {1'b0, r} : {1'b0, r} + 6'h0C;
    endfunction

    task cmd(input iaa_op_e op, input logic [1:0] ix, input logic [4:0] s,
             input logic [4:0] d, input logic [7:0] n);
        int k;
        @(posedge core_clk);
        cmd_op <= op;
        cmd_ix <= ix;
        cmd_src <= s;
        cmd_dst <= d;
        cmd_imm <= n;
        cmd_amode <= am;
        cmd_imode <= im;
        cmd_dst_mem <= dm;
        bank_sel <= bk;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        k = 0;
        #1;
        while (done !== 1'b1 && k < 40) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk(done, 1'b1, "command never finished");
    endtask

    task chkr(input logic [4:0] r, input logic [7:0] e);
        @(posedge core_clk);
        peek_sel <= ph(r);
        @(posedge core_clk);
        #1;
        chk(peek_data, e, "register content");
    endtask

    task setr(input logic [4:0] r, input logic [7:0] v);
        cmd(OP_MOV_IR, 2'h0, 5'h00, 5'h0F, v);
        cmd(OP_MOV_RR, 2'h0, 5'h0F, r, 8'h00);
    endtask

    task setp(input logic [1:0] ix, input logic [15:0] v);
        setr(5'h18 + 5'(2 * ix), v[7:0]);
        setr(5'h19 + 5'(2 * ix), v[15:8]);
    endtask

    task chkp(input logic [1:0] ix, input logic [15:0] e);
        chkr(5'h18 + 5'(2 * ix), e[7:0]);
        chkr(5'h19 + 5'(2 * ix), e[15:8]);
    endtask

    task alu(input iaa_op_e op, input logic [4:0] d, input logic [7:0] n,
             input logic [7:0] e);
        cmd(op, 2'h0, 5'h0D, d, n);
        chkr(d, e);
    endtask

    task t_reset;
        for (int i = 0; i < 4; i++) chkp(2'(i), 16'h0000);
    endtask

    task t_modes;
        logic [15:0] e;
        logic [15:0] a;
        e = 16'h10FF;
        setp(2'h0, e);
        for (int m = 0; m < 4; m++) begin
            wait_cyc = 4'(m);
            setr(5'h02, 8'h40 + 8'(m));
            im = iaa_imode_e'(m);
            cmd(OP_MOV_RM, 2'h0, 5'h02, 5'h00, 8'h00);
            a = (m == 3) ? e + 16'h0001 : e;
            chk(mem(a), 8'h40 + 8'(m), "indexed write");
            e = (m == 1) ? e - 16'h0001 : (m == 0) ? e : e + 16'h0001;
            chkp(2'h0, e);
        end
        im = IM_HOLD;
        cmd(OP_MOV_MR, 2'h0, 5'h00, 5'h09, 8'h00);
        chkr(5'h09, 8'h43);
    endtask

    task t_rel;
        setp(2'h3, 16'hFFF0);
        iaa_dmem_model_inst.store[16'h0010] = 8'h5A;
        am = AM_IMM_REL;
        im = IM_POST_INC;
        cmd(OP_MOV_MR, 2'h0, 5'h00, 5'h13, 8'h20);
        chkr(5'h03, 8'h5A);
        chkp(2'h3, 16'hFFF0);
        setr(5'h00, 8'h80);
        setp(2'h1, 16'h1234);
        setr(5'h04, 8'h66);
        am = AM_REG_REL;
        cmd(OP_MOV_RM, 2'h1, 5'h04, 5'h00, 8'h00);
        chk(mem(16'h12B4), 8'h66, "register relative");
        setp(2'h0, 16'h2000);
        dm = 1'b1;
        cmd(OP_ADD_A, 2'h0, 5'h04, 5'h00, 8'h00);
        chk(mem(16'h2000), 8'hE6, "relative on add");
        am = AM_INDEXED;
        im = IM_HOLD;
        dm = 1'b0;
    endtask

    task t_alu;
        setr(5'h00, 8'h70);
        setr(5'h0D, 8'h30);
        setr(5'h07, 8'h7F);
        alu(OP_SUB_A, 5'h06, 8'h00, 8'hC0);
        chk(flag_carry, 1'b1, "borrow");
        alu(OP_ADC_A, 5'h06, 8'h00, 8'hA1);
        alu(OP_SBC_A, 5'h06, 8'h00, 8'hC0);
        alu(OP_SBC_A, 5'h06, 8'h00, 8'hBF);
        chk(flag_neg, 1'b1, "negative");
        alu(OP_ADD_A, 5'h06, 8'h00, 8'hA0);
        chk(flag_ovf, 1'b1, "signed overflow");
        alu(OP_AND_A, 5'h06, 8'h00, 8'h30);
        alu(OP_OR_A, 5'h06, 8'h00, 8'h70);
        alu(OP_XOR_A, 5'h06, 8'h00, 8'h40);
        chkr(5'h0D, 8'h30);
        alu(OP_ADD_I, 5'h07, 8'h01, 8'h80);
        alu(OP_SUB_I, 5'h07, 8'h01, 8'h7F);
        alu(OP_AND_I, 5'h07, 8'h0F, 8'h0F);
        alu(OP_OR_I, 5'h07, 8'hF0, 8'hFF);
        alu(OP_XOR_I, 5'h07, 8'hAA, 8'h55);
        alu(OP_INV, 5'h07, 8'h00, 8'hAA);
        alu(OP_AND_I, 5'h07, 8'h00, 8'h00);
        chk(flag_zero, 1'b1, "zero");
        bk = 1'b1;
        setr(5'h00, 8'h01);
        alu(OP_ADD_A, 5'h06, 8'h00, 8'h31);
        bk = 1'b0;
    endtask

    task t_misc;
        setp(2'h2, 16'h3456);
        im = IM_POST_INC;
        cmd(OP_MOV_IM, 2'h2, 5'h00, 5'h00, 8'hC3);
        chk(mem(16'h3456), 8'hC3, "immediate store");
        chkp(2'h2, 16'h3456);
        im = IM_HOLD;
        cmd(OP_ABSOLUTE_LONG_JUMP_IX, 2'h2, 5'h00, 5'h00, 8'h00);
        chk(jump_addr, 16'h3456, "jump target");
    endtask

    initial begin
        fail_count = 0;
        total_checks = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = OP_MOV_RR;
        {cmd_ix, cmd_src, cmd_dst, cmd_imm, peek_sel} = '0;
        {cmd_dst_mem, bank_sel, dm, bk, wait_cyc} = '0;
        am = AM_INDEXED;
        im = IM_HOLD;
        cmd_amode = am;
        cmd_imode = im;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_modes;
        t_rel;
        t_alu;
        t_misc;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        final_report;
    end
endmodule
